// File: rtl/bank_close_pkg.sv
// Shared constants, command codes and command-bus coding for the bank-close link
`default_nettype none
package bank_close_pkg;
  // Clocking: the controller divides sys_clk by CK_DIV to make the link clock
  localparam int SYS_PERIOD_PS = 25000;
  localparam int CK_PERIOD_PS = 200000;
  localparam int CK_DIV = CK_PERIOD_PS / SYS_PERIOD_PS;
  localparam logic [2:0] DIV_RISE_SETUP = 3'h5;
  localparam logic [2:0] DIV_FALL_SETUP = 3'h1;
  localparam logic [2:0] DIV_HIGH_END = 3'h3;

  localparam int BANKS = 8;
  localparam int CA_W = 10;
  localparam int LANES = 2;
  localparam int DQ_W = 8 * LANES;
  localparam int BEATS = 8;

  // Command-bus field positions
  localparam int CA_ALL_BANK = 4;
  localparam int CA_BANK_LSB = 7;
  localparam int CA_AUTO_CLOSE = 0;
  localparam logic [3:0] CA_PRE_CODE = 4'hb;
  localparam logic [1:0] CA_ACT_CODE = 2'h2;
  localparam logic [2:0] CA_READ_CODE = 3'h5;
  localparam logic [2:0] CA_WRITE_CODE = 3'h1;

  // Burst and latency
  localparam int BURST_LENGTH = 8;
  localparam int HALF_BURST = BURST_LENGTH / 2;
  localparam int WRITE_LATENCY_CYCLES = 4;

  // Analog times in picoseconds
  localparam int READ_TO_CLOSE_TIME_PS = 7500;
  localparam int WRITE_RECOVERY_TIME_PS = 15000;
  localparam int ROW_ACTIVE_MIN_TIME_PS = 42000;
  localparam int ROW_CYCLE_TIME_PS = 60000;
  localparam int SINGLE_BANK_CLOSE_TIME_PS = 18000;
  localparam int ALL_BANK_CLOSE_TIME_PS = 21000;

  // Least times round up to whole link clocks
  function automatic int ru_ck(input int ps);
    return (ps + CK_PERIOD_PS - 1) / CK_PERIOD_PS;
  endfunction

  localparam int RTP_CK = ru_ck(READ_TO_CLOSE_TIME_PS);
  localparam logic [3:0] WRITE_LAT_CK = 4'(WRITE_LATENCY_CYCLES);
  localparam logic [4:0] RD_CLOSE_CK = 5'(HALF_BURST + ((RTP_CK > 4) ? RTP_CK : 4) - 4);
  localparam logic [4:0] WR_CLOSE_CK =
    5'(WRITE_LATENCY_CYCLES + HALF_BURST + 1 + ru_ck(WRITE_RECOVERY_TIME_PS));
  localparam logic [4:0] ROW_ACTIVE_MIN_CK = 5'(ru_ck(ROW_ACTIVE_MIN_TIME_PS));
  localparam logic [4:0] ROW_CYCLE_CK = 5'(ru_ck(ROW_CYCLE_TIME_PS));
  localparam logic [4:0] SINGLE_CLOSE_CK = 5'(ru_ck(SINGLE_BANK_CLOSE_TIME_PS));
  localparam logic [4:0] ALL_CLOSE_CK = 5'(ru_ck(ALL_BANK_CLOSE_TIME_PS));

  // Controller register port
  localparam logic [3:0] REG_CMD = 4'h0;
  localparam logic [3:0] REG_WDATA = 4'h4;
  localparam logic [3:0] REG_WMASK = 4'h8;
  localparam logic [3:0] REG_STATUS = 4'hc;
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_BANK_LSB = 2;
  localparam int CMD_ALL_BIT = 5;
  localparam int CMD_AUTO_CLOSE_BIT = 6;

  typedef enum logic [2:0] {CMD_NONE, CMD_ACT, CMD_READ, CMD_WRITE, CMD_PRE} cmd_t;

  function automatic cmd_t decode_cmd(input logic cs_n, input logic [CA_W-1:0] ca);
    cmd_t c;
    c = CMD_NONE;
    if (!cs_n) begin
      if (ca[1:0] == CA_ACT_CODE) begin
        c = CMD_ACT;
      end else if (ca[1:0] == CA_READ_CODE[1:0]) begin
        c = ca[2] ? CMD_READ : CMD_WRITE;
      end else if (ca[3:0] == CA_PRE_CODE) begin
        c = CMD_PRE;
      end
    end
    return c;
  endfunction

  function automatic logic [CA_W-1:0] encode_rise(input cmd_t c, input logic [2:0] bank,
                                                  input logic all);
    logic [CA_W-1:0] ca;
    ca = '0;
    ca[CA_BANK_LSB +: 3] = bank;
    unique case (c)
      CMD_NONE: ca = '0;
      CMD_ACT: ca[1:0] = CA_ACT_CODE;
      CMD_READ: ca[2:0] = CA_READ_CODE;
      CMD_WRITE: ca[2:0] = CA_WRITE_CODE;
      CMD_PRE: begin
        ca[3:0] = CA_PRE_CODE;
        ca[CA_ALL_BANK] = all;
      end
    endcase
    return ca;
  endfunction
endpackage
`default_nettype wire

// File: rtl/bank_link_if.sv
// Link between the memory controller and the memory device
`default_nettype none
interface bank_link_if;
  import bank_close_pkg::*;
  logic ck;
  logic cs_n;
  logic [CA_W-1:0] ca;
  logic [DQ_W-1:0] dq;
  logic [LANES-1:0] write_byte_mask;
  modport ctrl (output ck, output cs_n, output ca, output dq, output write_byte_mask);
  modport dev (input ck, input cs_n, input ca, input dq, input write_byte_mask);
endinterface
`default_nettype wire

// File: rtl/bank_close_dev.sv
// Memory device end: command decode, bank state, masked write capture, auto-close
`default_nettype none
module bank_close_dev
  import bank_close_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  bank_link_if.dev link,
  input wire logic [2:0] peek_bank,
  input wire logic [2:0] peek_beat,
  output logic [DQ_W-1:0] peek_data,
  output logic [BANKS-1:0] bank_open
);
  localparam int SW = 2 + CA_W + DQ_W + LANES;

  typedef struct packed {
    logic [SW-1:0] s1;
    logic [SW-1:0] s2;
    logic ck_prev;
    logic rcs_n;
    logic [CA_W-1:0] rca;
    logic [BANKS-1:0] open;
    logic [BANKS-1:0][4:0] close_cnt;
    logic [3:0] wr_wait;
    logic wact;
    logic [2:0] beat;
    logic [2:0] wbank;
    logic [BEATS-1:0][DQ_W-1:0] buffer;
    logic [BEATS-1:0][LANES-1:0] bmask;
    logic [BANKS-1:0][BEATS-1:0][DQ_W-1:0] mem;
    logic [DQ_W-1:0] peek;
  } dev_t;

  dev_t st;
  dev_t next_st;

  logic ck_s;
  logic cs_s;
  logic [CA_W-1:0] ca_s;
  logic [DQ_W-1:0] dq_s;
  logic [LANES-1:0] m_s;

  // Mask travels in the same synchroniser word as data, so both see one path
  assign ck_s = st.s2[SW-1];
  assign cs_s = st.s2[SW-2];
  assign ca_s = st.s2[SW-3 -: CA_W];
  assign dq_s = st.s2[LANES +: DQ_W];
  assign m_s = st.s2[LANES-1:0];

  always_comb begin
    cmd_t c;
    logic rise;
    logic fall;
    logic cap;
    logic [2:0] idx;
    logic [2:0] b;
    next_st = st;
    c = CMD_NONE;
    b = st.rca[CA_BANK_LSB +: 3];
    next_st.s1 = {link.ck, link.cs_n, link.ca, link.dq, link.write_byte_mask};
    next_st.s2 = st.s1;
    next_st.ck_prev = ck_s;
    rise = ck_s && !st.ck_prev;
    fall = !ck_s && st.ck_prev;
    next_st.peek = st.mem[peek_bank][peek_beat];
    if (rise) begin
      next_st.rcs_n = cs_s;
      next_st.rca = ca_s;
      for (int i = 0; i < BANKS; i++) begin
        if (st.close_cnt[i] != 5'h0) begin
          next_st.close_cnt[i] = st.close_cnt[i] - 5'h1;
          if (st.close_cnt[i] == 5'h1) begin
            next_st.open[i] = 1'b0;
          end
        end
      end
      if (st.wr_wait != 4'h0) begin
        next_st.wr_wait = st.wr_wait - 4'h1;
      end
    end
    // Beat 0 lands on the rise write latency after the command, then every edge
    cap = (rise && st.wr_wait == 4'h1) || ((rise || fall) && st.wact);
    idx = st.wact ? st.beat : 3'h0;
    if (cap) begin
      next_st.buffer[idx] = dq_s;
      next_st.bmask[idx] = m_s;
      next_st.beat = idx + 3'h1;
      next_st.wact = 1'b1;
      if (idx == 3'(BEATS - 1)) begin
        // Array write only once the whole prefetch group is latched
        next_st.wact = 1'b0;
        for (int j = 0; j < BEATS; j++) begin
          for (int l = 0; l < LANES; l++) begin
            if (!next_st.bmask[j][l]) begin
              next_st.mem[st.wbank][j][l*8 +: 8] = next_st.buffer[j][l*8 +: 8];
            end
          end
        end
      end
    end
    // Decode at the fall, once the falling-edge auto-close bit is present
    if (fall) begin
      c = decode_cmd(st.rcs_n, st.rca);
      unique case (c)
        CMD_NONE: next_st.wr_wait = next_st.wr_wait;
        CMD_ACT: next_st.open[b] = 1'b1;
        CMD_PRE: begin
          if (st.rca[CA_ALL_BANK]) begin
            next_st.open = '0;
            next_st.close_cnt = '0;
          end else begin
            next_st.open[b] = 1'b0;
            next_st.close_cnt[b] = 5'h0;
          end
        end
        CMD_READ: begin
          if (ca_s[CA_AUTO_CLOSE]) begin
            next_st.close_cnt[b] = RD_CLOSE_CK;
          end
        end
        CMD_WRITE: begin
          next_st.wr_wait = WRITE_LAT_CK;
          next_st.wbank = b;
          if (ca_s[CA_AUTO_CLOSE]) begin
            next_st.close_cnt[b] = WR_CLOSE_CK;
          end
        end
      endcase
      // Auto-close low leaves the bank open: no counter is armed
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign peek_data = st.peek;
  assign bank_open = st.open;
endmodule
`default_nettype wire

// File: rtl/bank_close_ctrl.sv
// Memory controller end: register port, link clock divider, command scheduling
//
// Chosen here: the plain strobed port and the register offsets.
`default_nettype none
// Functional notes
// - One write byte mask per data byte
// - Masked beat leaves its byte unwritten
// - Mask captured exactly like write data
// - Precharge is CS low, CA3..0 = 1011
// - CA4 high closes all, else CA9..7 bank
// - Activate waits all- or single-bank close time
// - All-bank close delay kept separate, longer
// - Precharge no sooner than half burst after read
// - Precharge waits minimum row-active time
// - Activate waits row close time after precharge
// - Read-to-close counted from half burst minus four
// - Write-to-precharge: latency, half burst, one, recovery
// - Array write after full eight-beat group
// - Close an open bank before activating again
// - Auto-close low keeps bank open
// - Auto-close high closes bank automatically
// - Read auto-close after half burst or read-to-close
// - After read auto-close, activate waits close and cycle
// - Write auto-close after write recovery
// - After write auto-close, activate waits close and cycle
// - Read/write CS low CA1..0 = 01, CA2 read
// - Close period counts from latest precharge
module bank_close_ctrl
  import bank_close_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  bank_link_if.ctrl link
);
  typedef struct packed {
    logic [2:0] div;
    logic ck;
    logic cs_n;
    logic [CA_W-1:0] ca;
    logic [DQ_W-1:0] dq;
    logic [LANES-1:0] lane_mask;
    logic [DQ_W-1:0] wdat;
    logic [BEATS*LANES-1:0] wmask;
    logic pend;
    cmd_t p_cmd;
    logic [2:0] p_bank;
    logic p_all;
    logic p_auto;
    logic err;
    logic [BANKS-1:0] open;
    logic [BANKS-1:0][4:0] pre_wait;
    logic [BANKS-1:0][4:0] act_wait;
    logic issued;
    logic fall_auto;
    logic wact;
    logic [3:0] wslot;
    logic [2:0] widx;
    logic [15:0] rdata;
  } ctrl_t;

  // Reset inside the low phase so the first high phase is full length
  localparam ctrl_t CTRL_RST = '{cs_n: 1'b1, p_cmd: CMD_NONE, div: DIV_HIGH_END + 3'h1,
                                 default: '0};

  ctrl_t st;
  ctrl_t next_st;

  function automatic logic [4:0] mx(input logic [4:0] a, input logic [4:0] b);
    return (a > b) ? a : b;
  endfunction

  // Beat data is the programmed word plus the beat number, with its two mask bits
  function automatic logic [LANES+DQ_W-1:0] beat_of(input logic [DQ_W-1:0] base,
                                                     input logic [BEATS*LANES-1:0] m,
                                                     input logic [2:0] beat);
    return {m[beat*LANES +: LANES], base + {13'h0, beat}};
  endfunction

  always_comb begin
    cmd_t issue;
    cmd_t op;
    logic busy;
    logic all_ready;
    logic [2:0] b;
    logic [3:0] ns;
    logic [2:0] bi;
    next_st = st;
    issue = CMD_NONE;
    op = CMD_NONE;
    b = st.p_bank;
    ns = st.wslot + 4'h1;
    bi = 3'h0;
    all_ready = 1'b1;
    busy = st.pend || st.wact;
    next_st.div = st.div + 3'h1;
    next_st.ck = (next_st.div <= DIV_HIGH_END);

    next_st.rdata = '0;
    if (rd) begin
      unique case (addr)
        REG_STATUS: next_st.rdata = {st.open, 6'h0, st.err, busy};
        REG_WDATA: next_st.rdata = st.wdat;
        REG_WMASK: next_st.rdata = st.wmask;
        default: next_st.rdata = '0;
      endcase
    end
    if (wr) begin
      unique case (addr)
        REG_CMD: begin
          if (busy) begin
            next_st.err = 1'b1;
          end else begin
            unique case (wdata[CMD_OP_LSB +: 2])
              2'h0: op = CMD_ACT;
              2'h1: op = CMD_READ;
              2'h2: op = CMD_WRITE;
              2'h3: op = CMD_PRE;
            endcase
            next_st.pend = 1'b1;
            next_st.err = 1'b0;
            next_st.p_cmd = op;
            next_st.p_bank = wdata[CMD_BANK_LSB +: 3];
            next_st.p_all = wdata[CMD_ALL_BIT];
            next_st.p_auto = wdata[CMD_AUTO_CLOSE_BIT];
          end
        end
        REG_WDATA: next_st.wdat = wdata;
        REG_WMASK: next_st.wmask = wdata;
        default: next_st.err = st.err;
      endcase
    end

    // One command slot per link clock, set up ahead of the rising edge
    if (st.div == DIV_RISE_SETUP) begin
      next_st.cs_n = 1'b1;
      next_st.ca = '0;
      next_st.issued = 1'b0;
      for (int i = 0; i < BANKS; i++) begin
        if (st.pre_wait[i] != 5'h0) begin
          next_st.pre_wait[i] = st.pre_wait[i] - 5'h1;
        end
        if (st.act_wait[i] != 5'h0) begin
          next_st.act_wait[i] = st.act_wait[i] - 5'h1;
        end
        if (next_st.pre_wait[i] != 5'h0) begin
          all_ready = 1'b0;
        end
      end
      // A pending command is held until its spacing is met; a read or write to a closed bank is dropped with an error
      if (st.pend && !st.wact) begin
        unique case (st.p_cmd)
          CMD_NONE: next_st.pend = 1'b0;
          CMD_ACT: begin
            if (st.open[b]) begin
              if (next_st.pre_wait[b] == 5'h0) begin
                issue = CMD_PRE;
              end
            end else if (next_st.act_wait[b] == 5'h0) begin
              issue = CMD_ACT;
            end
          end
          CMD_READ, CMD_WRITE: begin
            if (!st.open[b]) begin
              next_st.err = 1'b1;
              next_st.pend = 1'b0;
            end else begin
              issue = st.p_cmd;
            end
          end
          CMD_PRE: begin
            if (st.p_all ? all_ready : (next_st.pre_wait[b] == 5'h0)) begin
              issue = CMD_PRE;
            end
          end
        endcase
      end
      if (issue != CMD_NONE) begin
        next_st.cs_n = 1'b0;
        next_st.ca = encode_rise(issue, b, st.p_all && st.p_cmd == CMD_PRE);
        next_st.issued = 1'b1;
        next_st.fall_auto = st.p_auto;
        if (issue == st.p_cmd) begin
          next_st.pend = 1'b0;
        end
      end
      unique case (issue)
        CMD_NONE: next_st.issued = next_st.issued;
        CMD_ACT: begin
          next_st.open[b] = 1'b1;
          next_st.pre_wait[b] = ROW_ACTIVE_MIN_CK;
          next_st.act_wait[b] = ROW_CYCLE_CK;
        end
        CMD_PRE: begin
          if (st.p_all && st.p_cmd == CMD_PRE) begin
            next_st.open = '0;
            for (int i = 0; i < BANKS; i++) begin
              next_st.act_wait[i] = ALL_CLOSE_CK;
            end
          end else begin
            next_st.open[b] = 1'b0;
            next_st.act_wait[b] = SINGLE_CLOSE_CK;
          end
        end
        CMD_READ: begin
          next_st.pre_wait[b] = mx(next_st.pre_wait[b], RD_CLOSE_CK);
          if (st.p_auto) begin
            next_st.open[b] = 1'b0;
            next_st.act_wait[b] = mx(next_st.act_wait[b], RD_CLOSE_CK + SINGLE_CLOSE_CK);
          end
        end
        CMD_WRITE: begin
          next_st.pre_wait[b] = mx(next_st.pre_wait[b], WR_CLOSE_CK);
          next_st.wact = 1'b1;
          next_st.wslot = 4'h0;
          if (st.p_auto) begin
            next_st.open[b] = 1'b0;
            next_st.act_wait[b] = mx(next_st.act_wait[b], WR_CLOSE_CK + SINGLE_CLOSE_CK);
          end
        end
      endcase
      // Even beats are set up ahead of each rise from write latency onward
      if (st.wact) begin
        next_st.wslot = ns;
        if (ns >= WRITE_LAT_CK && ns < WRITE_LAT_CK + 4'(HALF_BURST)) begin
          bi = 3'(2 * (ns - WRITE_LAT_CK));
          {next_st.lane_mask, next_st.dq} = beat_of(st.wdat, st.wmask, bi);
          next_st.widx = bi + 3'h1;
        end
      end
    end

    if (st.div == DIV_FALL_SETUP) begin
      if (st.issued) begin
        next_st.ca = '0;
        next_st.ca[CA_AUTO_CLOSE] = st.fall_auto;
      end
      if (st.wact && st.wslot >= WRITE_LAT_CK) begin
        {next_st.lane_mask, next_st.dq} = beat_of(st.wdat, st.wmask, st.widx);
        next_st.widx = st.widx + 3'h1;
        if (st.widx == 3'(BEATS - 1)) begin
          next_st.wact = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= CTRL_RST;
    end else begin
      st <= next_st;
    end
  end

  assign rdata = st.rdata;
  assign link.ck = st.ck;
  assign link.cs_n = st.cs_n;
  assign link.ca = st.ca;
  assign link.dq = st.dq;
  assign link.write_byte_mask = st.lane_mask;
endmodule
`default_nettype wire

// File: dv/bank_close_properties.sv
// Link checks between the controller and device ends
`default_nettype none
module bank_close_properties
  import bank_close_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ck,
  input wire logic cs_n,
  input wire logic [CA_W-1:0] ca
);
  timeunit 1ns;
  timeprecision 1ps;
  // Spacing in link clock rises after a read or write command
  localparam int RD_GAP = HALF_BURST + ((RTP_CK > 4) ? RTP_CK : 4) - 4;
  localparam int WR_GAP = WRITE_LATENCY_CYCLES + HALF_BURST + 1
    + (WRITE_RECOVERY_TIME_PS + CK_PERIOD_PS - 1) / CK_PERIOD_PS;
  localparam int CLOSE_GAP = (SINGLE_BANK_CLOSE_TIME_PS + CK_PERIOD_PS - 1) / CK_PERIOD_PS;
  logic ck_q, pend, last_rd, last_auto;
  logic [2:0] last_bank;
  logic [4:0] gap;
  logic [BANKS-1:0] open_seen;
  wire logic rise = ck && !ck_q;
  wire logic sel = rise && !cs_n;
  wire logic is_act = sel && ca[1:0] == 2'h2;
  wire logic is_rw = sel && ca[1:0] == 2'h1;
  wire logic is_pre = sel && ca[3:0] == 4'hb;
  wire logic [2:0] bank = ca[9:7];
  wire logic hit = ca[4] || bank == last_bank;
  // Auto-close is booked at the command's fall: any use of the bank before it closes is illegal
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ck_q <= 1'b0;
      pend <= 1'b0;
      last_rd <= 1'b0;
      last_auto <= 1'b0;
      last_bank <= 3'h0;
      gap <= 5'h1f;
      open_seen <= '0;
    end else begin
      ck_q <= ck;
      if (rise) gap <= (gap == 5'h1f) ? gap : gap + 5'h1;
      if (is_act) open_seen[bank] <= 1'b1;
      if (is_pre && ca[4]) open_seen <= '0;
      if (is_pre && !ca[4]) open_seen[bank] <= 1'b0;
      if (is_pre && hit) last_auto <= 1'b0;
      if (is_rw) begin
        gap <= 5'h0;
        pend <= 1'b1;
        last_rd <= ca[2];
        last_bank <= bank;
        last_auto <= 1'b0;
      end
      if (!ck && ck_q && pend) begin
        pend <= 1'b0;
        last_auto <= ca[0];
        if (ca[0]) open_seen[last_bank] <= 1'b0;
      end
    end
  end
  default clocking dc @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  a_ck_shape: assert property ($rose(ck) |-> ck[*4] ##1 !ck[*4] ##1 ck)
    else $error("link clock not four high and four low");
  a_cs_period: assert property ($fell(cs_n) |-> !cs_n[*8])
    else $error("select shorter than one link clock");
  a_cmd_code: assert property (sel |-> is_act || is_rw || is_pre)
    else $error("unknown command code on the link");
  a_ca_held: assert property (sel |-> $stable(ca))
    else $error("command bits move at the link clock rise");
  a_read_pre_gap: assert property (is_pre && hit && last_rd |-> int'(gap) + 1 >= RD_GAP)
    else $error("precharge too soon after read");
  a_write_pre_gap: assert property (is_pre && hit && !last_rd |-> int'(gap) + 1 >= WR_GAP)
    else $error("precharge too soon after write");
  a_act_after_auto: assert property (is_act && last_auto && bank == last_bank |->
    int'(gap) + 1 >= (last_rd ? RD_GAP : WR_GAP) + CLOSE_GAP)
    else $error("activate too soon after auto-close");
  a_act_closed: assert property (is_act |-> !open_seen[bank])
    else $error("activate to a bank still open");
  a_rw_open: assert property (is_rw |-> open_seen[bank])
    else $error("access to a closed bank reached the link");
  c_pre_all: cover property (is_pre && ca[4]);
  c_write_auto: cover property (!ck && ck_q && pend && ca[0] && !last_rd);
  c_read_auto: cover property (!ck && ck_q && pend && ca[0] && last_rd);
endmodule
`default_nettype wire

// File: dv/tb_bank_close_and_write_mask.sv
// Self-checking bench: controller and device joined over the link
`default_nettype none
module tb_bank_close_and_write_mask
  import bank_close_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] rdata;
  logic [2:0] peek_bank = 3'h0;
  logic [2:0] peek_beat = 3'h0;
  logic [DQ_W-1:0] peek_data;
  logic [BANKS-1:0] bank_open;
  logic [31:0] seed = 32'h286f;
  logic [15:0] s;
  logic [15:0] cur_wd = 16'h0;
  logic [15:0] cur_wm = 16'h0;
  logic [BANKS-1:0] m_open = '0;
  logic m_err = 1'b0;
  logic extra_err = 1'b0;
  logic [15:0] m_mem [BANKS][BEATS] = '{default: 16'h0};
  int bad_count = 0;
  int total_checks = 0;
  always #12.5 sys_clk = ~sys_clk;
  bank_link_if bank_link_if_i ();
  bank_close_ctrl bank_close_ctrl_i (.sys_clk(sys_clk), .rst_n(rst_n), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .link(bank_link_if_i));
  bank_close_dev bank_close_dev_i (.sys_clk(sys_clk), .rst_n(rst_n), .link(bank_link_if_i),
    .peek_bank(peek_bank), .peek_beat(peek_beat), .peek_data(peek_data), .bank_open(bank_open));
  bank_close_properties bank_close_properties_i (.sys_clk(sys_clk), .rst_n(rst_n),
    .ck(bank_link_if_i.ck), .cs_n(bank_link_if_i.cs_n), .ca(bank_link_if_i.ca));
  function automatic logic [31:0] next_rand(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic wreg(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rreg(input logic [3:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic set_data(input logic [15:0] d, input logic [15:0] m);
    wreg(REG_WDATA, d);
    wreg(REG_WMASK, m);
    cur_wd = d;
    cur_wm = m;
  endtask
  task automatic check_bank(input logic [2:0] b);
    for (int i = 0; i < BEATS; i++) begin
      @(posedge sys_clk);
      peek_bank <= b;
      peek_beat <= 3'(i);
      repeat (2) @(posedge sys_clk);
      #1;
      chk(peek_data, m_mem[b][i]);
    end
  endtask
  // Wait for idle, then let a write's auto-close (ten link clocks) land before comparing
  task automatic finish_cmd(input logic [1:0] op, input logic [2:0] b, input logic all,
                            input logic ac);
    logic [15:0] st;
    logic [15:0] d;
    int n;
    st = 16'h1;
    n = 0;
    while (st[0] !== 1'b0 && n < 500) begin
      rreg(REG_STATUS, st);
      n++;
    end
    repeat (96) @(posedge sys_clk);
    #1;
    m_err = extra_err || ((op[0] ^ op[1]) && !m_open[b]);
    extra_err = 1'b0;
    if (op == 2'h0) m_open[b] = 1'b1;
    if (op == 2'h3 && all) m_open = '0;
    if (op == 2'h3 && !all) m_open[b] = 1'b0;
    for (int i = 0; i < BEATS; i++) begin
      d = cur_wd + 16'(i);
      for (int l = 0; l < LANES; l++) begin
        if (op == 2'h2 && m_open[b] && !cur_wm[2 * i + l]) m_mem[b][i][8 * l +: 8] = d[8 * l +: 8];
      end
    end
    if ((op[0] ^ op[1]) && ac) m_open[b] = 1'b0;
    chk({8'h0, bank_open}, {8'h0, m_open});
    rreg(REG_STATUS, st);
    chk(st, {m_open, 6'h0, m_err, 1'b0});
    if (op == 2'h2) check_bank(b);
  endtask
  task automatic run_cmd(input logic [1:0] op, input logic [2:0] b, input logic all,
                         input logic ac);
    wreg(REG_CMD, {9'h0, ac, all, b, op});
    finish_cmd(op, b, all, ac);
  endtask
  initial begin
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    rreg(REG_STATUS, s);
    chk(s, 16'h0);
    chk({8'h0, bank_open}, 16'h0);
    rreg(4'h2, s);
    chk(s, 16'h0);
    $display("test reset done");
    for (int b = 0; b < BANKS; b++) run_cmd(2'h0, 3'(b), 1'b0, 1'b0);
    run_cmd(2'h3, 3'h5, 1'b0, 1'b0);
    run_cmd(2'h3, 3'h2, 1'b1, 1'b0);
    $display("test precharge done");
    run_cmd(2'h0, 3'h3, 1'b0, 1'b0);
    set_data(16'h12fe, 16'h0000);
    run_cmd(2'h2, 3'h3, 1'b0, 1'b0);
    set_data(16'h5a5a, 16'hffff);
    run_cmd(2'h2, 3'h3, 1'b0, 1'b0);
    set_data(16'h00ff, 16'h8004);
    run_cmd(2'h2, 3'h3, 1'b0, 1'b1);
    run_cmd(2'h2, 3'h3, 1'b0, 1'b0);
    run_cmd(2'h0, 3'h6, 1'b0, 1'b0);
    run_cmd(2'h1, 3'h6, 1'b0, 1'b0);
    run_cmd(2'h1, 3'h6, 1'b0, 1'b1);
    run_cmd(2'h0, 3'h6, 1'b0, 1'b0);
    $display("test mask and auto-close done");
    // A second order while busy is refused and flags an error
    // A write keeps the port busy through its burst, so the refusal never races the slot
    wreg(REG_CMD, 16'h001a);
    wreg(REG_CMD, 16'h0023);
    extra_err = 1'b1;
    finish_cmd(2'h2, 3'h6, 1'b0, 1'b0);
    $display("test busy refusal done");
    for (int k = 0; k < 60; k++) begin
      seed = next_rand(seed);
      if (seed[1:0] == 2'h2) set_data(seed[31:16], seed[23:8]);
      run_cmd(seed[1:0], seed[4:2], seed[5], seed[6]);
    end
    $display("test random traffic done");
    give_verdict();
  end
  // About 80 commands at under 500 cycles each fit well inside this span
  initial begin
    repeat (60000) @(posedge sys_clk);
    bad_count++;
    $display("mismatch at %0t: run did not finish", $time);
    give_verdict();
  end
endmodule
`default_nettype wire
